//--- src/tbtlp_pkg.sv
package tbtlp_pkg;

  // ==========================================================================
  // bus geometry and register indices (byte address is four times the index)
  localparam int unsigned ADDR_W         = 20;
  localparam int unsigned DATA_W         = 32;
  localparam logic [15:0] IDX_TIMER_MODE = 16'hffb0;
  localparam logic [15:0] IDX_TIMER_CNT  = 16'hffb1;
  localparam logic [15:0] IDX_PORT9      = 16'hffdc;
  localparam logic [15:0] IDX_IRQ_EN1    = 16'hfff3;
  localparam logic [15:0] IDX_IRQ_REQ1   = 16'hfff6;
  localparam logic [15:0] IDX_EVT_STAT   = 16'h0100;
  localparam logic [15:0] IDX_EVT_MASK   = 16'h0101;

  // ==========================================================================
  // field positions
  localparam int unsigned MODE_W         = 4;
  localparam int unsigned LED1_BIT       = 2;
  localparam int unsigned LED2_BIT       = 3;
  localparam int unsigned PORT9_PINS     = 6;
  localparam int unsigned TIMER_IEN_BIT  = 7;
  localparam int unsigned TIMER_IRQ_BIT  = 7;
  localparam int unsigned EVT_W          = 2;
  localparam int unsigned EVT_OVF_BIT    = 0;
  localparam int unsigned EVT_LOST_BIT   = 1;

  // ==========================================================================
  // clock-select codes: 10xx is time base, 11xx clears counter and prescaler
  localparam logic [1:0] SEL_TIMEBASE    = 2'h2;
  localparam logic [1:0] SEL_CLEAR       = 2'h3;
  localparam logic [3:0] MODE_TB_HALF    = 4'h9;

  // ==========================================================================
  // reset values
  localparam logic [3:0] RST_MODE        = 4'h0;
  localparam logic [7:0] RST_PORT9       = 8'h00;
  localparam logic       RST_IEN         = 1'b0;
  localparam logic [1:0] RST_EVT_MASK    = 2'h0;

  // ==========================================================================
  // timing: counts are in subclock edges, the subclock arrives on a pin
  localparam int unsigned SUBCLK_HZ      = 32768;
  localparam int unsigned PRE_IN_DIV     = 4;
  localparam int unsigned PRE_W          = 5;
  localparam int unsigned CNT_W          = 8;
  localparam int unsigned CNT_IN_DIV     = PRE_IN_DIV * (1 << PRE_W);
  localparam int unsigned HALF_SEC_MS    = 500;
  localparam int unsigned HALF_SEC_SUBCLK = SUBCLK_HZ * HALF_SEC_MS / 1000;
  localparam int unsigned HALF_SEC_COUNTS = HALF_SEC_SUBCLK / CNT_IN_DIV;

  // ==========================================================================
  // bus slave states
  typedef enum logic [1:0] {
    APB_IDLE   = 2'b01,
    APB_ANSWER = 2'b10
  } tbtlp_apb_state_t;

endpackage

//--- src/tbtlp_sync_rise.sv
`timescale 1ns/1ps
module tbtlp_sync_rise (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_ce,
  // asynchronous level in, rising-edge pulse out
  input  wire logic i_async,
  output logic      o_rise
);

  logic meta_r;
  logic sync_r;
  logic last_r;

  // ==========================================================================
  // two-stage synchroniser, edge taken only after the second stage
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else if (i_ce) begin
      meta_r <= i_async;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign o_rise = sync_r & ~last_r;

endmodule

//--- src/tbtlp_timebase.sv
`timescale 1ns/1ps
module tbtlp_timebase (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_ce,
  // control
  input  wire logic       i_sub_rise,
  input  wire logic       i_clear,
  input  wire logic [3:0] i_mode,
  // state
  output logic      [4:0] o_prescaler,
  output logic      [7:0] o_count,
  output logic            o_ovf
);

  logic [1:0] prediv_r;
  logic       pre_tick;
  logic       cnt_tick;

  // overflow period: bits of the counter that must be all ones
  function automatic logic [7:0] period_mask(input logic [3:0] mode);
    case (mode[1:0])
      2'h0:    period_mask = 8'hff;
      2'h1:    period_mask = 8'h7f;
      2'h2:    period_mask = 8'h3f;
      default: period_mask = 8'h07;
    endcase
  endfunction

  assign pre_tick = i_sub_rise &&
                    (prediv_r == 2'(tbtlp_pkg::PRE_IN_DIV - 1));
  assign cnt_tick = pre_tick && (o_prescaler == 5'h1f) &&
                    (i_mode[3:2] == tbtlp_pkg::SEL_TIMEBASE);
  assign o_ovf    = cnt_tick &&
                    ((o_count & period_mask(i_mode)) == period_mask(i_mode));

  // ==========================================================================
  // prescaler chain
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prediv_r    <= 2'h0;
      o_prescaler <= 5'h00;
    end else if (i_ce) begin
      if (i_clear) begin
        prediv_r    <= 2'h0;
        o_prescaler <= 5'h00;
      end else if (i_sub_rise) begin
        prediv_r <= prediv_r + 2'h1;
        if (pre_tick) begin
          o_prescaler <= o_prescaler + 5'h01;
        end
      end
    end
  end

  // ==========================================================================
  // eight-bit counter at subclock/128
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_count <= 8'h00;
    end else if (i_ce) begin
      if (i_clear) begin
        o_count <= 8'h00;
      end else if (cnt_tick) begin
        o_count <= o_count + 8'h01;
      end
    end
  end

  // ==========================================================================
  a_prescaler_step: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    i_ce && pre_tick && !i_clear |=> o_prescaler == $past(o_prescaler) + 5'h01)
    else $error("prescaler did not step on subclock/4 tick");

  a_count_source: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    i_ce && !i_clear && !(pre_tick && o_prescaler == 5'h1f) |=> $stable(o_count))
    else $error("counter moved without a prescaler wrap");

  a_count_step: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    i_ce && cnt_tick && !i_clear |=> o_count == $past(o_count) + 8'h01)
    else $error("counter missed a prescaler wrap");

  a_half_sec_ovf: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    i_mode == tbtlp_pkg::MODE_TB_HALF && cnt_tick |-> o_ovf == (o_count[6:0] == 7'h7f))
    else $error("half-second overflow at wrong count");

endmodule

//--- src/tbtlp_top.sv
// Added by the designer: the APB register port.
`timescale 1ns/1ps
// Overview of operation
// - five-bit prescaler counts subclock divided by four
// - eight-bit counter counts subclock divided by 128
// - select code 1001 gives half-second time base
// - counter takes prescaler output as its clock
// - port 9 latch is eight bits wide
// - port 9 reads return latch, not pins
// - latch bit 3 drives LED2 pin level
// - latch bit 2 drives LED1 pin level
// - enable bit 7 gates the timer interrupt
// - request bit 7 reads pending timer request
module tbtlp_top (
  // clock and reset
  input  wire logic                         i_core_clk,
  input  wire logic                         i_rst_b,
  input  wire logic                         i_ce,
  // apb slave
  input  wire logic                         i_psel,
  input  wire logic                         i_penable,
  input  wire logic                         i_pwrite,
  input  wire logic [tbtlp_pkg::ADDR_W-1:0] i_paddr,
  input  wire logic [tbtlp_pkg::DATA_W-1:0] i_pwdata,
  output logic                              o_pready,
  output logic      [tbtlp_pkg::DATA_W-1:0] o_prdata,
  output logic                              o_pslverr,
  // subclock pin
  input  wire logic                         i_subclk,
  // port pins and interrupt
  output logic      [5:0]                   o_port9,
  output logic                              o_led1,
  output logic                              o_led2,
  output logic                              o_irq
);

  // ==========================================================================
  // declarations
  tbtlp_pkg::tbtlp_apb_state_t state_r;
  tbtlp_pkg::tbtlp_apb_state_t state_nxt;

  logic [3:0] timer_mode_a_r;
  logic [7:0] port9_output_latch_r;
  logic       timer_irq_enable_r;
  logic       timer_irq_flag_r;
  logic       timer_irq_flag_nxt;
  logic [1:0] evt_status_r;
  logic [1:0] evt_status_nxt;
  logic [1:0] evt_mask_r;
  logic [1:0] evt_set;
  logic [4:0] subclock_prescaler;
  logic [7:0] timer_count_a;
  logic       sub_rise;
  logic       ovf;
  logic       tb_clear;
  logic       acc;
  logic       wr_acc;
  logic       rd_acc;
  logic       hit_any;
  logic [31:0] rd_value;

  // address match for a register index
  function automatic logic hit(input logic [19:0] addr, input logic [15:0] idx);
    hit = (addr == {2'b00, idx, 2'b00});
  endfunction

  // ==========================================================================
  // subclock crossing and time base
  tbtlp_sync_rise u_sync (
    .i_clk   (i_core_clk),
    .i_rst_b (i_rst_b),
    .i_ce    (i_ce),
    .i_async (i_subclk),
    .o_rise  (sub_rise)
  );

  tbtlp_timebase u_timebase (
    .i_clk       (i_core_clk),
    .i_rst_b     (i_rst_b),
    .i_ce        (i_ce),
    .i_sub_rise  (sub_rise),
    .i_clear     (tb_clear),
    .i_mode      (timer_mode_a_r),
    .o_prescaler (subclock_prescaler),
    .o_count     (timer_count_a),
    .o_ovf       (ovf)
  );

  // ==========================================================================
  // apb handshake: one wait state, answer on the second access edge
  always_comb begin
    case (state_r)
      tbtlp_pkg::APB_IDLE: begin
        state_nxt = (i_psel && i_penable) ? tbtlp_pkg::APB_ANSWER : tbtlp_pkg::APB_IDLE;
      end
      tbtlp_pkg::APB_ANSWER: begin
        state_nxt = tbtlp_pkg::APB_IDLE;
      end
      default: begin
        state_nxt = tbtlp_pkg::APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r  <= tbtlp_pkg::APB_IDLE;
      o_pready <= 1'b0;
    end else if (i_ce) begin
      state_r  <= state_nxt;
      o_pready <= (state_nxt == tbtlp_pkg::APB_ANSWER);
    end
  end

  assign acc    = i_psel && i_penable && o_pready;
  assign wr_acc = acc && i_pwrite && hit_any;
  assign rd_acc = acc && !i_pwrite && hit_any;

  assign hit_any = hit(i_paddr, tbtlp_pkg::IDX_TIMER_MODE) ||
                   hit(i_paddr, tbtlp_pkg::IDX_TIMER_CNT) ||
                   hit(i_paddr, tbtlp_pkg::IDX_PORT9) ||
                   hit(i_paddr, tbtlp_pkg::IDX_IRQ_EN1) ||
                   hit(i_paddr, tbtlp_pkg::IDX_IRQ_REQ1) ||
                   hit(i_paddr, tbtlp_pkg::IDX_EVT_STAT) ||
                   hit(i_paddr, tbtlp_pkg::IDX_EVT_MASK);

  // ==========================================================================
  // read mux; unused bits read zero
  always_comb begin
    rd_value = 32'h0000_0000;
    if (hit(i_paddr, tbtlp_pkg::IDX_TIMER_MODE)) begin
      rd_value[3:0] = timer_mode_a_r;
    end else if (hit(i_paddr, tbtlp_pkg::IDX_TIMER_CNT)) begin
      rd_value[7:0] = timer_count_a;
    end else if (hit(i_paddr, tbtlp_pkg::IDX_PORT9)) begin
      rd_value[7:0] = port9_output_latch_r;
    end else if (hit(i_paddr, tbtlp_pkg::IDX_IRQ_EN1)) begin
      rd_value[tbtlp_pkg::TIMER_IEN_BIT] = timer_irq_enable_r;
    end else if (hit(i_paddr, tbtlp_pkg::IDX_IRQ_REQ1)) begin
      rd_value[tbtlp_pkg::TIMER_IRQ_BIT] = timer_irq_flag_r;
    end else if (hit(i_paddr, tbtlp_pkg::IDX_EVT_STAT)) begin
      rd_value[1:0] = evt_status_r;
    end else if (hit(i_paddr, tbtlp_pkg::IDX_EVT_MASK)) begin
      rd_value[1:0] = evt_mask_r;
    end
  end

  // data and error are captured one edge ahead of the completing edge
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (i_ce) begin
      if (state_r == tbtlp_pkg::APB_IDLE && i_psel && i_penable) begin
        o_prdata  <= i_pwrite ? 32'h0000_0000 : rd_value;
        o_pslverr <= !hit_any;
      end else begin
        o_pslverr <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // software-written registers
  // writing 11xx also zeroes counter and prescaler, stored code stops the counter but not the prescaler
  assign tb_clear = wr_acc && hit(i_paddr, tbtlp_pkg::IDX_TIMER_MODE) &&
                    (i_pwdata[3:2] == tbtlp_pkg::SEL_CLEAR);

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      timer_mode_a_r       <= tbtlp_pkg::RST_MODE;
      port9_output_latch_r <= tbtlp_pkg::RST_PORT9;
      timer_irq_enable_r   <= tbtlp_pkg::RST_IEN;
      evt_mask_r           <= tbtlp_pkg::RST_EVT_MASK;
    end else if (i_ce && wr_acc) begin
      if (hit(i_paddr, tbtlp_pkg::IDX_TIMER_MODE)) begin
        // select bits steer the time base
        timer_mode_a_r <= i_pwdata[3:0];
      end
      if (hit(i_paddr, tbtlp_pkg::IDX_PORT9)) begin
        port9_output_latch_r <= i_pwdata[7:0];
      end
      if (hit(i_paddr, tbtlp_pkg::IDX_IRQ_EN1)) begin
        timer_irq_enable_r <= i_pwdata[tbtlp_pkg::TIMER_IEN_BIT];
      end
      if (hit(i_paddr, tbtlp_pkg::IDX_EVT_MASK)) begin
        evt_mask_r <= i_pwdata[1:0];
      end
    end
  end

  // ==========================================================================
  // timer request flag: set beats a simultaneous zero write
  // sticky until written zero
  always_comb begin
    timer_irq_flag_nxt = timer_irq_flag_r;
    if (wr_acc && hit(i_paddr, tbtlp_pkg::IDX_IRQ_REQ1) &&
        !i_pwdata[tbtlp_pkg::TIMER_IRQ_BIT]) begin
      timer_irq_flag_nxt = 1'b0;
    end
    if (ovf) begin
      timer_irq_flag_nxt = 1'b1;
    end
  end

  // events: overflow, and overflow while the flag was still pending
  assign evt_set = {ovf && timer_irq_flag_r, ovf};

  always_comb begin
    evt_status_nxt = evt_status_r;
    if (rd_acc && hit(i_paddr, tbtlp_pkg::IDX_EVT_STAT)) begin
      // clear only what the captured read data showed: an event that lands
      // between capture and completion stays pending instead of being lost
      evt_status_nxt = evt_status_r & ~o_prdata[1:0];
    end
    evt_status_nxt = evt_status_nxt | evt_set;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      timer_irq_flag_r <= 1'b0;
      evt_status_r     <= 2'h0;
    end else if (i_ce) begin
      timer_irq_flag_r <= timer_irq_flag_nxt;
      evt_status_r     <= evt_status_nxt;
    end
  end

  // ==========================================================================
  // registered pins
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_port9 <= 6'h00;
      o_led1  <= 1'b0;
      o_led2  <= 1'b0;
      o_irq   <= 1'b0;
    end else if (i_ce) begin
      o_port9 <= port9_output_latch_r[tbtlp_pkg::PORT9_PINS-1:0];
      o_led1  <= port9_output_latch_r[tbtlp_pkg::LED1_BIT];
      o_led2  <= port9_output_latch_r[tbtlp_pkg::LED2_BIT];
      o_irq   <= (timer_irq_flag_r && timer_irq_enable_r) || |(evt_status_r & evt_mask_r);
    end
  end

  // ==========================================================================
  // checks
  sequence s_port9_write;
    i_ce && wr_acc && hit(i_paddr, tbtlp_pkg::IDX_PORT9);
  endsequence

  sequence s_flag_kept;
    i_ce && timer_irq_flag_r &&
    !(wr_acc && hit(i_paddr, tbtlp_pkg::IDX_IRQ_REQ1) && !i_pwdata[7]);
  endsequence

  a_ovf_sets_flag: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    i_ce && ovf |=> timer_irq_flag_r)
    else $error("overflow did not set the request flag");

  a_flag_sticky: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    s_flag_kept |=> timer_irq_flag_r)
    else $error("request flag dropped without a zero write");

  a_led_pins: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    s_port9_write ##1 i_ce |=>
      o_led2 == $past(i_pwdata[3], 2) && o_led1 == $past(i_pwdata[2], 2))
    else $error("LED pins do not follow latch write");

  a_port9_readback: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    rd_acc && hit(i_paddr, tbtlp_pkg::IDX_PORT9) |-> o_prdata[7:0] == port9_output_latch_r)
    else $error("port 9 read does not return latch");

  a_req_readback: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    rd_acc && hit(i_paddr, tbtlp_pkg::IDX_IRQ_REQ1) && $past(i_ce) |->
      o_prdata[7] == $past(timer_irq_flag_r))
    else $error("request read does not show flag");

  a_irq_gated: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    i_ce && !timer_irq_enable_r && !(|(evt_status_r & evt_mask_r)) |=> !o_irq)
    else $error("interrupt raised while disabled");

  a_irq_raised: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    i_ce && timer_irq_enable_r && timer_irq_flag_r |=> o_irq)
    else $error("enabled request not raised");

  a_ready_pulse: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    o_pready && i_ce |=> !o_pready)
    else $error("ready held longer than one cycle");

endmodule

//--- verif/tbtlp_led_pair.sv
`timescale 1ns/1ps
module tbtlp_led_pair #(
  parameter logic LIT_LEVEL = 1'b1
) (
  // observation clock
  input  wire logic i_clk,
  // led pins
  input  wire logic i_led1,
  input  wire logic i_led2,
  // lamp state
  output logic      o_lit1,
  output logic      o_lit2,
  output int        o_swaps
);
  // ==========================================================================
  // lamps: an unknown pin level never counts as lit
  assign o_lit1 = (i_led1 === LIT_LEVEL);
  assign o_lit2 = (i_led2 === LIT_LEVEL);

  // ==========================================================================
  // swap counter: both lamps flip together and end up opposite
  logic prev1;
  logic prev2;
  int   swaps_q = 0;

  assign o_swaps = swaps_q;

  always @(posedge i_clk) begin
    if (i_led1 !== prev1 && i_led2 !== prev2 && i_led1 !== i_led2) begin
      swaps_q <= swaps_q + 1;
    end
    prev1 <= i_led1;
    prev2 <= i_led2;
  end
endmodule

//--- verif/tbtlp_bench.sv
`timescale 1ns/1ps
module tbtlp_bench;
  // ==========================================================================
  // signals
  localparam int LIMIT = 80000;
  logic                         i_core_clk;
  logic                         i_rst_b;
  logic                         i_ce;
  logic                         i_psel;
  logic                         i_penable;
  logic                         i_pwrite;
  logic [tbtlp_pkg::ADDR_W-1:0] i_paddr;
  logic [tbtlp_pkg::DATA_W-1:0] i_pwdata;
  logic                         o_pready;
  logic [tbtlp_pkg::DATA_W-1:0] o_prdata;
  logic                         o_pslverr;
  logic                         i_subclk;
  logic [5:0]                   o_port9;
  logic                         o_led1;
  logic                         o_led2;
  logic                         o_irq;
  logic                         lit1;
  logic                         lit2;
  int                           swaps;
  int                           errors;
  int                           num_checks;
  int                           cyc;
  int                           t0;
  int                           t1;
  int                           s0;
  logic [31:0]                  rd;
  logic                         err;
  logic                         hi;
  logic [15:0] regs [7] = '{tbtlp_pkg::IDX_TIMER_MODE, tbtlp_pkg::IDX_TIMER_CNT,
    tbtlp_pkg::IDX_PORT9, tbtlp_pkg::IDX_IRQ_EN1, tbtlp_pkg::IDX_IRQ_REQ1,
    tbtlp_pkg::IDX_EVT_MASK, tbtlp_pkg::IDX_EVT_STAT};
  logic [7:0]  pats [5] = '{8'h04, 8'h08, 8'hf3, 8'h0c, 8'h00};

  tbtlp_top u_tbtlp_top (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_ce       (i_ce),
    .i_psel     (i_psel),
    .i_penable  (i_penable),
    .i_pwrite   (i_pwrite),
    .i_paddr    (i_paddr),
    .i_pwdata   (i_pwdata),
    .o_pready   (o_pready),
    .o_prdata   (o_prdata),
    .o_pslverr  (o_pslverr),
    .i_subclk   (i_subclk),
    .o_port9    (o_port9),
    .o_led1     (o_led1),
    .o_led2     (o_led2),
    .o_irq      (o_irq)
  );

  tbtlp_led_pair u_tbtlp_led_pair (
    .i_clk   (i_core_clk),
    .i_led1  (o_led1),
    .i_led2  (o_led2),
    .o_lit1  (lit1),
    .o_lit2  (lit2),
    .o_swaps (swaps)
  );

  // ==========================================================================
  // clock, fast subclock and timeout
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  // subclock rises every second core cycle, so half a second is 32768 cycles
  always @(posedge i_core_clk) begin
    i_subclk <= ~i_subclk;
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      errors++;
      close_out();
    end
  end

  // ==========================================================================
  // tasks
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // request held until ready is seen at a rising edge; data taken at that edge
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    @(posedge i_core_clk);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= wr;
    i_paddr   <= {2'b00, idx, 2'b00};
    i_pwdata  <= {24'h000000, wd};
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    do @(posedge i_core_clk); while (o_pready !== 1'b1);
    rd  = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd);
  endtask

  task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp, input string what);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h000000, exp}, what);
    chk({31'h0, err}, 32'h0, "error flag");
  endtask

  // skip two cycles first: a just-cleared request leaves the output high one more
  task automatic wait_irq();
    int c;
    c = 0;
    repeat (2) @(negedge i_core_clk);
    while (o_irq !== 1'b1 && c < 40000) begin
      @(negedge i_core_clk);
      c++;
    end
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    errors = 0;
    num_checks = 0;
    cyc = 0;
    i_rst_b = 1'b0;
    i_ce = 1'b1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = '0;
    i_pwdata = '0;
    i_subclk = 1'b0;
    repeat (20) @(posedge i_core_clk);
    chk({23'h0, o_irq, o_led2, o_led1, o_port9}, 32'h0, "outputs in reset");
    i_rst_b <= 1'b1;
    foreach (regs[i]) rdchk(regs[i], 8'h00, "reset value");
    apb(1'b1, 16'h0200, 8'hff);
    chk({31'h0, err}, 32'h1, "unmapped write");
    apb(1'b0, 16'h0200, 8'h00);
    chk({err, rd[30:0]}, 32'h80000000, "unmapped read");
    foreach (pats[i]) begin
      wr(tbtlp_pkg::IDX_PORT9, pats[i]);
      rdchk(tbtlp_pkg::IDX_PORT9, pats[i], "latch readback");
      chk({o_led2, o_led1, o_port9}, {pats[i][3], pats[i][2], pats[i][5:0]}, "pins");
    end
    wr(tbtlp_pkg::IDX_TIMER_CNT, 8'h55);
    rdchk(tbtlp_pkg::IDX_TIMER_CNT, 8'h00, "count read only");
    // ========================================================================
    // short overflow period, software swaps lamps on each request
    wr(tbtlp_pkg::IDX_PORT9, 8'h04);
    wr(tbtlp_pkg::IDX_TIMER_MODE, 8'h0f);
    wr(tbtlp_pkg::IDX_IRQ_EN1, 8'h80);
    wr(tbtlp_pkg::IDX_TIMER_MODE, 8'h0b);
    wait_irq();
    t0 = cyc;
    rdchk(tbtlp_pkg::IDX_TIMER_CNT, 8'h08, "count at overflow");
    rdchk(tbtlp_pkg::IDX_IRQ_REQ1, 8'h80, "flag set");
    wr(tbtlp_pkg::IDX_IRQ_REQ1, 8'h80);
    rdchk(tbtlp_pkg::IDX_IRQ_REQ1, 8'h80, "flag kept");
    s0 = swaps;
    repeat (3) begin
      apb(1'b0, tbtlp_pkg::IDX_PORT9, 8'h00);
      wr(tbtlp_pkg::IDX_PORT9, rd[7:0] ^ 8'h0c);
      wr(tbtlp_pkg::IDX_IRQ_REQ1, 8'h00);
      wait_irq();
      t1 = cyc;
      chk(32'(t1 - t0), 32'd2048, "overflow period");
      t0 = t1;
    end
    chk(32'(swaps - s0), 32'd3, "lamp swaps");
    chk({30'h0, lit2, lit1}, 32'h2, "lamp state");
    // ========================================================================
    // enable low freezes the time base; an even stall keeps the subclock phase
    wr(tbtlp_pkg::IDX_IRQ_REQ1, 8'h00);
    i_ce <= 1'b0;
    repeat (512) @(posedge i_core_clk);
    i_ce <= 1'b1;
    wait_irq();
    chk(32'(cyc - t0), 32'd2560, "stalled period");
    // ========================================================================
    // enable off: only masked events interrupt, flag and events still recorded
    rdchk(tbtlp_pkg::IDX_EVT_STAT, 8'h01, "overflow event");
    wr(tbtlp_pkg::IDX_IRQ_EN1, 8'h00);
    // output drops one edge after the enable write completes
    repeat (2) @(negedge i_core_clk);
    hi = 1'b0;
    repeat (2100) begin
      @(negedge i_core_clk);
      hi = hi | (o_irq === 1'b1);
    end
    chk({31'h0, hi}, 32'h0, "gated interrupt");
    rdchk(tbtlp_pkg::IDX_IRQ_REQ1, 8'h80, "flag while gated");
    rdchk(tbtlp_pkg::IDX_EVT_STAT, 8'h03, "overflow while pending");
    rdchk(tbtlp_pkg::IDX_EVT_STAT, 8'h00, "status cleared by read");
    wr(tbtlp_pkg::IDX_EVT_MASK, 8'h01);
    wait_irq();
    chk({31'h0, o_irq}, 32'h1, "event interrupt");
    rdchk(tbtlp_pkg::IDX_EVT_STAT, 8'h03, "event status");
    repeat (2) @(negedge i_core_clk);
    chk({31'h0, o_irq}, 32'h0, "interrupt after read");
    wr(tbtlp_pkg::IDX_EVT_MASK, 8'h00);
    // ========================================================================
    // half-second time base
    wr(tbtlp_pkg::IDX_IRQ_REQ1, 8'h00);
    wr(tbtlp_pkg::IDX_IRQ_EN1, 8'h80);
    wr(tbtlp_pkg::IDX_TIMER_MODE, 8'h0f);
    wr(tbtlp_pkg::IDX_TIMER_MODE, tbtlp_pkg::MODE_TB_HALF);
    t0 = cyc;
    wait_irq();
    t1 = cyc - t0 - 32768;
    chk({31'h0, (t1 >= -16 && t1 <= 16)}, 32'h1, "half second");
    // code 1010: sixty-four counts, a quarter second
    wr(tbtlp_pkg::IDX_IRQ_REQ1, 8'h00);
    wr(tbtlp_pkg::IDX_TIMER_MODE, 8'h0f);
    wr(tbtlp_pkg::IDX_TIMER_MODE, 8'h0a);
    t0 = cyc;
    wait_irq();
    t1 = cyc - t0 - 16384;
    chk({31'h0, (t1 >= -16 && t1 <= 16)}, 32'h1, "quarter second");
    close_out();
  end
endmodule
